// ### test/etc_cpu_model.sv
// Software model that reaches the timer registers over the plain port.
`timescale 1ns/1ns
module etc_cpu_model
   import etc_pkg::*;
(
   input wire logic i_clk,           // Clock.
   input wire logic [7:0] i_rdata,   // Read data.
   output logic [ETC_AW-1:0] o_addr, // Address.
   output logic [7:0] o_wdata,       // Write data.
   output logic o_wr,                // Write strobe.
   output logic o_rd                 // Read strobe.
);
   initial begin
      o_addr = 3'h0;
      o_wdata = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   // safe software habits.
   // Idle lines are scrambled so a stale address or value can never pass as valid.
   task automatic wr(input logic [ETC_AW-1:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~d;
   endtask
   task automatic rd(input logic [ETC_AW-1:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      o_addr <= ~a;
      #1;
      d = i_rdata;
   endtask
endmodule

// ### test/etc_timer_asserts.sv
// Port-level checks of the timer compare unit.
`timescale 1ns/1ns
module etc_timer_asserts
   import etc_pkg::*;
(
   input wire logic i_clk,              // Clock.
   input wire logic i_rst,              // Reset.
   input wire logic [ETC_AW-1:0] i_addr, // Address.
   input wire logic [7:0] i_wdata,      // Write data.
   input wire logic i_wr,               // Write strobe.
   input wire logic i_rd,               // Read strobe.
   input wire logic i_ext_clk,          // Pin.
   input wire logic i_presc_rst,        // Prescaler reset.
   input wire logic [7:0] o_rdata,      // Read data.
   input wire logic o_compare_output,   // Output state.
   input wire logic o_cmp_irq,          // Compare request.
   input wire logic o_ovf_irq           // Overflow request.
);
   typedef struct packed {
      logic [2:0] cs;
      logic [1:0] msk;
      logic gie;
   } etc_chk_t;
   etc_chk_t ck_r;
   etc_chk_t ck_nxt;
   logic ctl_w, frc_w, quiet_w, cw_w, cr_w;
   assign ctl_w = i_wr && i_addr == ETC_OFF_CONTROL;
   assign frc_w = ctl_w && i_wdata[ETC_FOC_BIT] && !i_wdata[3];
   // A stopped timer has no tick, so nothing but a force may move the output.
   assign quiet_w = ctl_w && ck_r.cs == 3'h0 && i_wdata[2:0] == 3'h0 && (!i_wdata[7] || i_wdata[3]);
   assign cw_w = i_wr && i_addr == ETC_OFF_COUNTER && ck_r.cs == 3'h0;
   assign cr_w = i_rd && i_addr == ETC_OFF_COUNTER;
   always_comb begin
      ck_nxt = ck_r;
      if (i_wr && i_addr == ETC_OFF_CONTROL) begin
         ck_nxt.cs = i_wdata[2:0];
      end
      if (i_wr && i_addr == ETC_OFF_MASK) begin
         ck_nxt.msk = i_wdata[1:0];
      end
      if (i_wr && i_addr == ETC_OFF_STATUS) begin
         ck_nxt.gie = i_wdata[ETC_GIE_BIT];
      end
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ck_r <= '0;
      end else begin
         ck_r <= ck_nxt;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (i_rd && i_addr[2:1] == 2'h3 |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_stop_readback: assert property (cw_w ##2 cr_w |=> o_rdata == $past(i_wdata, 3))
      else $error("stopped counter lost written value");
   a_cmp_gated: assert property (o_cmp_irq |-> (ck_r.gie || $past(ck_r.gie)) && (ck_r.msk[1] || $past(ck_r.msk[1])))
      else $error("compare request without enables");
   a_ovf_gated: assert property (o_ovf_irq |-> (ck_r.gie || $past(ck_r.gie)) && (ck_r.msk[0] || $past(ck_r.msk[0])))
      else $error("overflow request without enables");
   a_force_set: assert property (frc_w && i_wdata[6:5] == ETC_COM_SET |-> ##[1:3] o_compare_output)
      else $error("forced set missing");
   a_force_clear: assert property (frc_w && i_wdata[6:5] == ETC_COM_CLEAR |-> ##[1:3] !o_compare_output)
      else $error("forced clear missing");
   a_force_toggle: assert property (frc_w && i_wdata[6:5] == ETC_COM_TOGGLE |-> ##[1:3] $changed(o_compare_output))
      else $error("forced toggle missing");
   a_mode_keeps: assert property (quiet_w |=> $stable(o_compare_output) [*3])
      else $error("output moved without match or force");
   c_force: cover property (frc_w);
   c_cmp_irq: cover property ($rose(o_cmp_irq));
   c_ovf_irq: cover property ($rose(o_ovf_irq));
endmodule
bind etc_timer etc_timer_asserts u_etc_timer_asserts (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_ext_clk(i_ext_clk), .i_presc_rst(i_presc_rst),
   .o_rdata(o_rdata), .o_compare_output(o_compare_output), .o_cmp_irq(o_cmp_irq), .o_ovf_irq(o_ovf_irq));

// ### test/etc_timer_bench.sv
// Self-checking bench of the timer compare unit.
`timescale 1ns/1ns
module etc_timer_bench;
   import etc_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_ext_clk = 1'b0;
   logic i_presc_rst = 1'b0;
   logic [ETC_AW-1:0] addr;
   logic [7:0] wdata, rdata, v, r;
   logic bus_wr, bus_rd, cmp_out, cmp_irq, ovf_irq, out;
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   int seed = 32'hd20a;
   int divs [6] = '{0, 1, 8, 64, 256, 1024};
   logic [7:0] frc [8] = '{8'he0, 8'hc0, 8'hb0, 8'hb0, 8'hf8, 8'ha8, 8'ha0, 8'h18};
   // Each row: mode, compare, counter start, expected compare and overflow flags.
   logic [19:0] rows [8] = '{{2'h0, 8'h08, 8'h06, 2'h2}, {2'h0, 8'h08, 8'h08, 2'h0}, {2'h0, 8'h40, 8'h30, 2'h0},
      {2'h3, 8'h1e, 8'h1c, 2'h0}, {2'h2, 8'h1e, 8'h1c, 2'h2}, {2'h0, 8'h40, 8'hfd, 2'h1},
      {2'h1, 8'h40, 8'hfd, 2'h0}, {2'h3, 8'h40, 8'hfd, 2'h1}};
   etc_timer u_etc_timer (.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(bus_wr),
      .i_rd(bus_rd), .i_ext_clk(i_ext_clk), .i_presc_rst(i_presc_rst), .o_rdata(rdata),
      .o_compare_output(cmp_out), .o_cmp_irq(cmp_irq), .o_ovf_irq(ovf_irq));
   etc_cpu_model u_etc_cpu_model (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
      .o_wr(bus_wr), .o_rd(bus_rd));
   always #2 i_clk = ~i_clk;
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      if (err_count == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   function automatic logic fexp(input logic [7:0] c, input logic cur);
      if (!c[ETC_FOC_BIT] || c[3]) begin
         return cur;
      end
      case (c[6:5])
         ETC_COM_SET: return 1'b1;
         ETC_COM_CLEAR: return 1'b0;
         ETC_COM_TOGGLE: return !cur;
         default: return cur;
      endcase
   endfunction
   task automatic run(input logic [7:0] c, input int n);
      u_etc_cpu_model.wr(ETC_OFF_CONTROL, c);
      repeat (n) @(posedge i_clk);
      u_etc_cpu_model.wr(ETC_OFF_CONTROL, {c[7:3], 3'h0});
   endtask
   task automatic row(input int i);
      u_etc_cpu_model.wr(ETC_OFF_CONTROL, {3'h0, rows[i][19:18], 3'h0});
      u_etc_cpu_model.wr(ETC_OFF_COMPARE, rows[i][17:10]);
      u_etc_cpu_model.wr(ETC_OFF_COUNTER, rows[i][9:2]);
      u_etc_cpu_model.wr(ETC_OFF_FLAG, 8'h03);
      run({3'h0, rows[i][19:18], ETC_CS_DIV1}, 6);
      u_etc_cpu_model.rd(ETC_OFF_FLAG, r);
   endtask
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         wrap_up;
      end
   end
   initial begin
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      for (int a = 0; a < 8; a++) begin
         u_etc_cpu_model.rd(3'(a), r);
         chk(r, 8'h00);
      end
      repeat (16) begin
         v = 8'($random(seed));
         u_etc_cpu_model.wr(ETC_OFF_COUNTER, v);
         u_etc_cpu_model.rd(ETC_OFF_COUNTER, r);
         chk(r, v);
      end
      u_etc_cpu_model.wr(ETC_OFF_CONTROL, {5'h0, ETC_CS_DIV1});
      repeat (8) begin
         v = 8'($random(seed));
         u_etc_cpu_model.wr(ETC_OFF_COUNTER, v);
         u_etc_cpu_model.rd(ETC_OFF_COUNTER, r);
         chk(r, 8'(v + 8'h01));
      end
      u_etc_cpu_model.wr(ETC_OFF_CONTROL, 8'h00);
      out = 1'b0;
      foreach (frc[i]) begin
         u_etc_cpu_model.wr(ETC_OFF_CONTROL, frc[i]);
         repeat (3) @(posedge i_clk);
         out = fexp(frc[i], out);
         chk({7'h0, cmp_out}, {7'h0, out});
      end
      u_etc_cpu_model.rd(ETC_OFF_FLAG, r);
      chk(r, 8'h00);
      u_etc_cpu_model.rd(ETC_OFF_STATUS, r);
      chk(r, {6'h0, out, 1'b0});
      for (int k = 6; k < 8; k++) begin
         u_etc_cpu_model.wr(ETC_OFF_COUNTER, 8'h00);
         u_etc_cpu_model.wr(ETC_OFF_CONTROL, 8'(k));
         repeat (5) begin
            repeat (3) @(posedge i_clk);
            i_ext_clk <= 1'b1;
            repeat (3) @(posedge i_clk);
            i_ext_clk <= 1'b0;
         end
         repeat (4) @(posedge i_clk);
         u_etc_cpu_model.wr(ETC_OFF_CONTROL, 8'h00);
         u_etc_cpu_model.rd(ETC_OFF_COUNTER, r);
         chk(r, 8'h05);
      end
      // The prescaler is restarted first, so only the window edges blur the count.
      for (int k = 1; k < 6; k++) begin
         i_presc_rst <= 1'b1;
         u_etc_cpu_model.wr(ETC_OFF_COUNTER, 8'h00);
         i_presc_rst <= 1'b0;
         run(8'(k), 8 * divs[k]);
         u_etc_cpu_model.rd(ETC_OFF_COUNTER, r);
         chk({7'h0, r >= 8'h08 && r <= 8'h0c}, 8'h01);
      end
      foreach (rows[i]) begin
         row(i);
         chk(r & 8'h03, {6'h0, rows[i][1:0]});
      end
      // A buffered write is read back at once but must not reach the active compare without a top.
      u_etc_cpu_model.wr(ETC_OFF_COMPARE, 8'h5a);
      u_etc_cpu_model.rd(ETC_OFF_COMPARE, r);
      chk(r, 8'h5a);
      u_etc_cpu_model.wr(ETC_OFF_CONTROL, {3'h0, ETC_WGM_NORMAL, ETC_CS_STOP});
      u_etc_cpu_model.rd(ETC_OFF_COMPARE, r);
      chk(r, 8'h40);
      u_etc_cpu_model.wr(ETC_OFF_MASK, 8'h03);
      u_etc_cpu_model.wr(ETC_OFF_STATUS, 8'h01);
      row(0);
      repeat (2) @(posedge i_clk);
      chk({7'h0, cmp_irq}, 8'h01);
      u_etc_cpu_model.wr(ETC_OFF_STATUS, 8'h03);
      repeat (2) @(posedge i_clk);
      chk({6'h0, cmp_irq, ovf_irq}, 8'h00);
      row(5);
      repeat (2) @(posedge i_clk);
      chk({6'h0, cmp_irq, ovf_irq}, 8'h01);
      u_etc_cpu_model.wr(ETC_OFF_STATUS, 8'h00);
      repeat (2) @(posedge i_clk);
      chk({7'h0, ovf_irq}, 8'h00);
      wrap_up;
   end
endmodule

// ### verilog/etc_pkg.sv
// Package with register map, field layout and encodings of the 8-bit timer compare unit.
package etc_pkg;
   localparam int ETC_AW = 3;
   // Register offsets.
   localparam logic [2:0] ETC_OFF_CONTROL = 3'h0;
   localparam logic [2:0] ETC_OFF_COUNTER = 3'h1;
   localparam logic [2:0] ETC_OFF_COMPARE = 3'h2;
   localparam logic [2:0] ETC_OFF_FLAG = 3'h3;
   localparam logic [2:0] ETC_OFF_MASK = 3'h4;
   localparam logic [2:0] ETC_OFF_STATUS = 3'h5;
   // Control register fields: [2:0] clock select, [4:3] waveform mode, [6:5] output mode, [7] force strobe.
   localparam int ETC_CS_LSB = 0;
   localparam int ETC_WGM_LSB = 3;
   localparam int ETC_COM_LSB = 5;
   localparam int ETC_FOC_BIT = 7;
   // Flag and mask register bits.
   localparam int ETC_OVF_BIT = 0;
   localparam int ETC_CMP_BIT = 1;
   // Status register bits: [0] global interrupt enable (written), [1] compare irq ack (written).
   localparam int ETC_GIE_BIT = 0;
   localparam int ETC_ACK_BIT = 1;
   localparam logic [7:0] ETC_BOTTOM = 8'h00;
   localparam logic [7:0] ETC_MAX = 8'hff;
   localparam logic [2:0] ETC_CS_STOP = 3'h0;
   localparam logic [2:0] ETC_CS_DIV1 = 3'h1;
   localparam logic [2:0] ETC_CS_DIV8 = 3'h2;
   localparam logic [2:0] ETC_CS_DIV64 = 3'h3;
   localparam logic [2:0] ETC_CS_DIV256 = 3'h4;
   localparam logic [2:0] ETC_CS_DIV1024 = 3'h5;
   localparam logic [2:0] ETC_CS_EXT_FALL = 3'h6;
   localparam logic [2:0] ETC_CS_EXT_RISE = 3'h7;
   localparam logic [9:0] ETC_TAP8 = 10'h007;
   localparam logic [9:0] ETC_TAP64 = 10'h03f;
   localparam logic [9:0] ETC_TAP256 = 10'h0ff;
   localparam logic [9:0] ETC_TAP1024 = 10'h3ff;
   localparam logic [1:0] ETC_WGM_NORMAL = 2'h0;
   localparam logic [1:0] ETC_WGM_PCPWM = 2'h1;
   localparam logic [1:0] ETC_WGM_CTC = 2'h2;
   localparam logic [1:0] ETC_WGM_FAST = 2'h3;
   localparam logic [1:0] ETC_COM_OFF = 2'h0;
   localparam logic [1:0] ETC_COM_TOGGLE = 2'h1;
   localparam logic [1:0] ETC_COM_CLEAR = 2'h2;
   localparam logic [1:0] ETC_COM_SET = 2'h3;
endpackage

// ### verilog/etc_timer.sv
// Single-channel 8-bit timer/counter with one output compare channel.
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ns
module etc_timer
   import etc_pkg::*;
(
   input wire logic i_clk,                  // System clock, 250 MHz.
   input wire logic i_rst,                  // Asynchronous reset, active high.
   input wire logic [ETC_AW-1:0] i_addr,    // Register address.
   input wire logic [7:0] i_wdata,          // Register write data.
   input wire logic i_wr,                   // Write strobe.
   input wire logic i_rd,                   // Read strobe.
   input wire logic i_ext_clk,              // External clock pin, synchronous.
   input wire logic i_presc_rst,            // Shared prescaler reset.
   output logic [7:0] o_rdata,              // Read data, one cycle after strobe.
   output logic o_compare_output,           // Compare output state.
   output logic o_cmp_irq,                  // Compare interrupt request.
   output logic o_ovf_irq                   // Overflow interrupt request.
);

   typedef struct packed {
      logic [7:0] cnt;
      logic [7:0] ocr;
      logic [7:0] ocr_buf;
      logic [2:0] cs;
      logic [1:0] wgm;
      logic [1:0] com;
      logic ovf_flag;
      logic cmp_flag;
      logic ovf_mask;
      logic cmp_mask;
      logic gie;
      logic down;
      logic block;
      logic match_pend;
      logic ext_d;
      logic [9:0] presc;
      logic oc;
      logic [7:0] rdata;
      logic cmp_irq;
      logic ovf_irq;
   } etc_state_t;

   etc_state_t st_r;
   etc_state_t st_nxt;

   // True for both PWM modes, where the compare register is buffered.
   function automatic logic etc_is_pwm(input logic [1:0] wgm);
      etc_is_pwm = (wgm == ETC_WGM_PCPWM) || (wgm == ETC_WGM_FAST);
   endfunction

   // Output update on a match for the given modes.
   function automatic logic etc_wave(input logic [1:0] com, input logic oc, input logic up_cnt, input logic pwm);
      etc_wave = oc;
      unique case (com)
         ETC_COM_OFF: etc_wave = oc;
         ETC_COM_TOGGLE: etc_wave = pwm ? oc : ~oc;
         ETC_COM_CLEAR: etc_wave = pwm ? ~up_cnt : 1'b0;
         ETC_COM_SET: etc_wave = pwm ? up_cnt : 1'b1;
      endcase
   endfunction

   // Mask of the prescaler bits that must all be ones for a divided tap to fire.
   function automatic logic [9:0] etc_tap_mask(input int idx);
      case (idx)
         0: etc_tap_mask = ETC_TAP8;
         1: etc_tap_mask = ETC_TAP64;
         2: etc_tap_mask = ETC_TAP256;
         default: etc_tap_mask = ETC_TAP1024;
      endcase
   endfunction

   // Tick from the selected source; the pin edge is judged against last cycle's sample.
   // tick source select
   function automatic logic etc_tick_sel(input logic [2:0] cs, input logic [3:0] taps, input logic ext_d,
                                         input logic ext_now);
      etc_tick_sel = 1'b0;
      unique case (cs)
         ETC_CS_STOP: etc_tick_sel = 1'b0;
         ETC_CS_DIV1: etc_tick_sel = 1'b1;
         ETC_CS_DIV8: etc_tick_sel = taps[0];
         ETC_CS_DIV64: etc_tick_sel = taps[1];
         ETC_CS_DIV256: etc_tick_sel = taps[2];
         ETC_CS_DIV1024: etc_tick_sel = taps[3];
         ETC_CS_EXT_FALL: etc_tick_sel = ext_d && !ext_now;
         ETC_CS_EXT_RISE: etc_tick_sel = !ext_d && ext_now;
      endcase
   endfunction

   // Strobe qualified by one register offset.
   function automatic logic etc_hit(input logic strobe, input logic [ETC_AW-1:0] addr,
                                    input logic [ETC_AW-1:0] off);
      etc_hit = strobe && (addr == off);
   endfunction

   // Register read multiplexer; the force strobe is write-only and so reads as zero.
   function automatic logic [7:0] etc_read_mux(input logic [ETC_AW-1:0] addr, input etc_state_t s);
      unique case (addr)
         ETC_OFF_CONTROL: etc_read_mux = {1'b0, s.com, s.wgm, s.cs};
         ETC_OFF_COUNTER: etc_read_mux = s.cnt;
         ETC_OFF_COMPARE: etc_read_mux = etc_is_pwm(s.wgm) ? s.ocr_buf : s.ocr;
         ETC_OFF_FLAG: etc_read_mux = {6'h00, s.cmp_flag, s.ovf_flag};
         ETC_OFF_MASK: etc_read_mux = {6'h00, s.cmp_mask, s.ovf_mask};
         ETC_OFF_STATUS: etc_read_mux = {6'h00, s.oc, s.gie};
         default: etc_read_mux = 8'h00;
      endcase
   endfunction

   logic tick;
   logic ovf_set;
   logic wr_mask;
   wire [3:0] tap_hit;

   // prescaler taps
   // The taps share one free-running divider, so a new selection may wait up to one full period.
   for (genvar g = 0; g < 4; g++) begin : g_tap
      assign tap_hit[g] = ((st_r.presc & etc_tap_mask(g)) == etc_tap_mask(g));
   end

   logic at_bottom;
   logic at_max;
   logic at_top;
   logic match;
   logic wr_ctl;
   logic wr_cnt;
   logic wr_cmp;
   logic wr_flag;
   logic wr_stat;

   always_comb begin
      st_nxt = st_r;
      ovf_set = 1'b0;
      wr_ctl = etc_hit(i_wr, i_addr, ETC_OFF_CONTROL);
      wr_cnt = etc_hit(i_wr, i_addr, ETC_OFF_COUNTER);
      wr_cmp = etc_hit(i_wr, i_addr, ETC_OFF_COMPARE);
      wr_flag = etc_hit(i_wr, i_addr, ETC_OFF_FLAG);
      wr_mask = etc_hit(i_wr, i_addr, ETC_OFF_MASK);
      wr_stat = etc_hit(i_wr, i_addr, ETC_OFF_STATUS);

      // Free-running shared prescaler; reset realigns all taps.
      st_nxt.presc = i_presc_rst ? 10'h000 : st_r.presc + 10'h001;
      st_nxt.ext_d = i_ext_clk;

      tick = etc_tick_sel(st_r.cs, tap_hit, st_r.ext_d, i_ext_clk);

      at_bottom = (st_r.cnt == ETC_BOTTOM);
      at_max = (st_r.cnt == ETC_MAX);
      at_top = (st_r.wgm == ETC_WGM_CTC) ? (st_r.cnt == st_r.ocr) : at_max;
      match = (st_r.cnt == st_r.ocr);

      // A match is latched and acted on at the next tick unless a counter write blocked it.
      if (tick) begin
         st_nxt.match_pend = 1'b0;
         st_nxt.block = 1'b0;
      end
      if (match && !st_r.block) begin
         st_nxt.match_pend = 1'b1;
      end

      if (tick) begin
         if (st_r.match_pend) begin
            st_nxt.cmp_flag = 1'b1;
            st_nxt.oc = etc_wave(st_r.com, st_r.oc, !st_r.down, etc_is_pwm(st_r.wgm));
         end
         unique case (st_r.wgm)
            ETC_WGM_NORMAL: begin
               st_nxt.cnt = st_r.cnt + 8'h01;
               st_nxt.down = 1'b0;
               if (at_max) begin
                  ovf_set = 1'b1;
               end
            end
            ETC_WGM_CTC: begin
               st_nxt.cnt = at_top ? ETC_BOTTOM : st_r.cnt + 8'h01;
               st_nxt.down = 1'b0;
               if (at_max) begin
                  ovf_set = 1'b1;
               end
            end
            ETC_WGM_FAST: begin
               st_nxt.cnt = at_max ? ETC_BOTTOM : st_r.cnt + 8'h01;
               st_nxt.down = 1'b0;
               if (at_max) begin
                  ovf_set = 1'b1;
                  st_nxt.ocr = st_r.ocr_buf;
               end
               // Non-inverted output sets at bottom, inverted clears.
               if (at_max && (st_r.com == ETC_COM_CLEAR)) begin
                  st_nxt.oc = 1'b1;
               end
               if (at_max && (st_r.com == ETC_COM_SET)) begin
                  st_nxt.oc = 1'b0;
               end
            end
            ETC_WGM_PCPWM: begin
               if (at_max) begin
                  st_nxt.down = 1'b1;
                  st_nxt.cnt = st_r.cnt - 8'h01;
                  st_nxt.ocr = st_r.ocr_buf;
               end else if (at_bottom) begin
                  st_nxt.down = 1'b0;
                  st_nxt.cnt = st_r.cnt + 8'h01;
                  ovf_set = 1'b1;
               end else begin
                  st_nxt.cnt = st_r.down ? st_r.cnt - 8'h01 : st_r.cnt + 8'h01;
               end
            end
         endcase
      end

      if (wr_cnt) begin
         st_nxt.cnt = i_wdata;
         st_nxt.block = 1'b1;
         st_nxt.match_pend = 1'b0;
      end

      if (wr_cmp) begin
         if (etc_is_pwm(st_r.wgm)) begin
            st_nxt.ocr_buf = i_wdata;
         end else begin
            st_nxt.ocr = i_wdata;
            st_nxt.ocr_buf = i_wdata;
         end
      end

      if (wr_ctl) begin
         st_nxt.cs = i_wdata[ETC_CS_LSB +: 3];
         st_nxt.wgm = i_wdata[ETC_WGM_LSB +: 2];
         st_nxt.com = i_wdata[ETC_COM_LSB +: 2];
         if (i_wdata[ETC_FOC_BIT] && !etc_is_pwm(i_wdata[ETC_WGM_LSB +: 2])) begin
            st_nxt.oc = etc_wave(i_wdata[ETC_COM_LSB +: 2], st_r.oc, 1'b1, 1'b0);
         end
      end

      if (wr_mask) begin
         st_nxt.ovf_mask = i_wdata[ETC_OVF_BIT];
         st_nxt.cmp_mask = i_wdata[ETC_CMP_BIT];
      end

      // clear by one or service
      // Hardware set in the same cycle wins over these clears.
      if (ovf_set) begin
         st_nxt.ovf_flag = 1'b1;
      end else if (wr_flag && i_wdata[ETC_OVF_BIT]) begin
         st_nxt.ovf_flag = 1'b0;
      end
      if (((wr_flag && i_wdata[ETC_CMP_BIT]) || (wr_stat && i_wdata[ETC_ACK_BIT]))
          && !(tick && st_r.match_pend)) begin
         st_nxt.cmp_flag = 1'b0;
      end
      if (wr_stat) begin
         st_nxt.gie = i_wdata[ETC_GIE_BIT];
      end

      st_nxt.cmp_irq = st_nxt.cmp_flag && st_nxt.cmp_mask && st_nxt.gie;
      st_nxt.ovf_irq = st_nxt.ovf_flag && st_nxt.ovf_mask && st_nxt.gie;

      // Read data stand for one cycle only; idle cycles return zero so no stale value lingers.
      st_nxt.rdata = 8'h00;
      if (i_rd) begin
         st_nxt.rdata = etc_read_mux(i_addr, st_r);
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_rdata = st_r.rdata;
   assign o_compare_output = st_r.oc;
   assign o_cmp_irq = st_r.cmp_irq;
   assign o_ovf_irq = st_r.ovf_irq;

endmodule
